/* rtl/rcsi_pkg.sv */
// rcsi_pkg: register offsets, field positions, reset values and vectors
// for the reset cause and initial state block; shared by design and bench
package rcsi_pkg;
	localparam logic [7:0]  ADR_RCAUSE   = 8'h00;
	localparam logic [7:0]  ADR_STACK    = 8'h04;
	localparam logic [7:0]  ADR_PC       = 8'h08;
	localparam logic [7:0]  ADR_TOS      = 8'h0c;
	localparam logic [7:0]  ADR_SPTR     = 8'h10;
	localparam logic [7:0]  ADR_PCLAT    = 8'h14;
	localparam logic [7:0]  ADR_TABLE_POINTER   = 8'h18;
	localparam logic [7:0]  ADR_TBLAT    = 8'h1c;
	localparam logic [7:0]  ADR_INTCTL   = 8'h20;
	localparam logic [7:0]  ADR_PIFLAG   = 8'h24;
	localparam logic [7:0]  ADR_PORTA    = 8'h28;
	localparam logic [7:0]  ADR_BUSST    = 8'h2c;
	localparam logic [7:0]  ADR_IRQ_ST   = 8'h30;
	localparam logic [7:0]  ADR_IRQ_MSK  = 8'h34;
	localparam logic [7:0]  ADR_OSCMODE  = 8'h38;
	localparam int          BUSST_COPIES = 4;
	// reset cause, stack and port fields
	localparam int          B_BOR        = 0;
	localparam int          B_POR        = 1;
	localparam int          B_PD         = 2;
	localparam int          B_TO         = 3;
	localparam int          B_RI         = 4;
	localparam int          B_IPEN       = 7;
	localparam int          B_STACK_OVERFLOW_FLAG     = 0;
	localparam int          B_STACK_UNDERFLOW_FLAG     = 1;
	localparam int          B_PORTA6     = 6;
	localparam logic [7:0]  RCAUSE_IMPL  = 8'h9f;
	localparam logic [7:0]  RCAUSE_POR   = 8'h1c;
	localparam logic [20:0] PC_RESET     = 21'h000000;
	localparam logic [20:0] VEC_HIGH     = 21'h000008;
	localparam logic [20:0] VEC_LOW      = 21'h000018;
	localparam logic [20:0] PC_STEP      = 21'h000002;
	localparam logic [4:0]  SPTR_RESET   = 5'h00;
	localparam logic [7:0]  BUSST_RESET  = 8'h80;
	localparam logic [7:0]  INTCTL_RESET = 8'h00;
	localparam logic [2:0]  OSC_EXT_CLOCK_IO_MODE     = 3'h1;
	localparam logic [2:0]  OSC_RC_OSC_IO_MODE     = 3'h2;
	// event status bits
	localparam int          EV_RESET     = 0;
	localparam int          EV_WAKE      = 1;
	localparam int          EV_STACK     = 2;
	localparam int          EV_N         = 3;
	typedef enum logic [3:0] {
		RCSI_SRC_NONE, RCSI_SRC_POR, RCSI_SRC_BOR, RCSI_SRC_MASTER_CLEAR_PIN, RCSI_SRC_MASTER_CLEAR_PIN_SLEEP,
		RCSI_SRC_SWRST, RCSI_SRC_STACK_OVERFLOW_FLAG, RCSI_SRC_STACK_UNDERFLOW_FLAG, RCSI_SRC_WDT,
		RCSI_SRC_WAKE_WDT, RCSI_SRC_WAKE_INT
	} rcsi_src_e;
endpackage : rcsi_pkg

/* rtl/rcsi_top.sv */
// rcsi_top: reset cause flags and core initial state, Wishbone classic slave
// assumes reset and wake events are single-cycle pulses synchronous to mclk
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rcsi_top #(
	parameter int PC_W = 21
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        por_evt,
	input  wire logic        bor_evt,
	input  wire logic        master_clear_pin_evt,
	input  wire logic        swrst_evt,
	input  wire logic        stack_overflow_flag_evt,
	input  wire logic        stack_underflow_flag_evt,
	input  wire logic        wdt_evt,
	input  wire logic        sleeping,
	input  wire logic        int_wake_evt,
	input  wire logic        int_high_prio,
	input  wire logic [7:0]  int_wake_src,
	input  wire logic        int_wake_is_pir,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [PC_W-1:0] pc_o,
	output logic             pc_load_o,
	output logic             core_rst_o,
	output logic             irq_o
);
	typedef struct packed {
		logic [7:0]      rcause;
		logic [1:0]      stk;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] tos;
		logic [4:0]      sptr;
		logic [15:0]     pclat;
		logic [21:0]     table_pointer;
		logic [7:0]      tblat;
		logic [7:0]      intctl;
		logic [7:0]      piflag;
		logic [7:0]      porta;
		logic [7:0]      busst;
		logic [2:0]      oscmode;
		logic [2:0]      ev;
		logic [2:0]      msk;
		logic            pcload;
		logic            crst;
		logic            ack;
		logic [31:0]     dat;
	} rcsi_state_s;

	rcsi_state_s s_r;
	rcsi_state_s s_nxt;
	rcsi_pkg::rcsi_src_e src;
	logic wr;
	logic rd;
	logic gie;
	logic [7:0] pa_mask;

	always_comb
	begin
		// priority: supply events first, then pin, then core events
		if (por_evt)
			src = rcsi_pkg::RCSI_SRC_POR;
		else if (bor_evt)
			src = rcsi_pkg::RCSI_SRC_BOR;
		else if (master_clear_pin_evt)
			src = sleeping ? rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN_SLEEP : rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN;
		else if (wdt_evt)
			src = sleeping ? rcsi_pkg::RCSI_SRC_WAKE_WDT : rcsi_pkg::RCSI_SRC_WDT;
		else if (swrst_evt)
			src = rcsi_pkg::RCSI_SRC_SWRST;
		else if (stack_overflow_flag_evt)
			src = rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG;
		else if (stack_underflow_flag_evt)
			src = rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG;
		else if (int_wake_evt && sleeping)
			src = rcsi_pkg::RCSI_SRC_WAKE_INT;
		else
			src = rcsi_pkg::RCSI_SRC_NONE;
	end

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !s_r.ack && wb_sel_i[0];
	assign rd = wb_cyc_i && wb_stb_i && !s_r.ack;
	assign gie = s_r.intctl[7] || s_r.intctl[6];
	// a bit-6 write in other modes is dropped, so the bit cannot reappear later
	assign pa_mask = (s_r.oscmode == rcsi_pkg::OSC_EXT_CLOCK_IO_MODE || s_r.oscmode == rcsi_pkg::OSC_RC_OSC_IO_MODE)
		? 8'hff : 8'hbf;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pcload = 1'b0;
		s_nxt.crst = 1'b0;
		s_nxt.ack = rd;
		// software writes first, so hardware events below win over a clear
		if (wr)
		begin
			case (wb_adr_i)
				rcsi_pkg::ADR_RCAUSE:
					s_nxt.rcause = wb_dat_i[7:0] & rcsi_pkg::RCAUSE_IMPL;
				rcsi_pkg::ADR_STACK:
					s_nxt.stk = s_r.stk & wb_dat_i[1:0];
				rcsi_pkg::ADR_INTCTL:
					s_nxt.intctl = wb_dat_i[7:0];
				rcsi_pkg::ADR_PIFLAG:
					s_nxt.piflag = wb_dat_i[7:0];
				rcsi_pkg::ADR_PORTA:
					s_nxt.porta = wb_dat_i[7:0] & pa_mask;
				rcsi_pkg::ADR_OSCMODE:
					s_nxt.oscmode = wb_dat_i[2:0];
				rcsi_pkg::ADR_IRQ_ST:
					s_nxt.ev = s_r.ev & ~wb_dat_i[2:0];
				rcsi_pkg::ADR_IRQ_MSK:
					s_nxt.msk = wb_dat_i[2:0];
				default:
					s_nxt.msk = s_r.msk;
			endcase
		end
		s_nxt.porta = s_nxt.porta & pa_mask;
		case (src)
			rcsi_pkg::RCSI_SRC_POR, rcsi_pkg::RCSI_SRC_BOR:
			begin
				s_nxt.rcause[rcsi_pkg::B_RI] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_TO] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_PD] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_BOR] = 1'b0;
				if (src == rcsi_pkg::RCSI_SRC_POR)
				begin
					s_nxt.rcause[rcsi_pkg::B_POR] = 1'b0;
					s_nxt.rcause[rcsi_pkg::B_IPEN] = 1'b0;
				end
			end
			rcsi_pkg::RCSI_SRC_SWRST:
				s_nxt.rcause[rcsi_pkg::B_RI] = 1'b0;
			rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG:
			begin
				s_nxt.rcause[rcsi_pkg::B_POR] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_BOR] = 1'b1;
				s_nxt.stk[rcsi_pkg::B_STACK_OVERFLOW_FLAG] = 1'b1;
			end
			rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG:
			begin
				s_nxt.rcause[rcsi_pkg::B_POR] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_BOR] = 1'b1;
				s_nxt.stk[rcsi_pkg::B_STACK_UNDERFLOW_FLAG] = 1'b1;
			end
			rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN_SLEEP:
			begin
				s_nxt.rcause[rcsi_pkg::B_TO] = 1'b1;
				s_nxt.rcause[rcsi_pkg::B_PD] = 1'b0;
			end
			rcsi_pkg::RCSI_SRC_WDT:
			begin
				s_nxt.rcause[rcsi_pkg::B_TO] = 1'b0;
				s_nxt.rcause[rcsi_pkg::B_PD] = 1'b1;
			end
			rcsi_pkg::RCSI_SRC_WAKE_WDT, rcsi_pkg::RCSI_SRC_WAKE_INT:
			begin
				s_nxt.rcause[rcsi_pkg::B_PD] = 1'b0;
				s_nxt.rcause[rcsi_pkg::B_TO] = (src == rcsi_pkg::RCSI_SRC_WAKE_INT);
			end
			default:
				s_nxt.crst = 1'b0;
		endcase
		// every reset source reinitialises the core state
		if (src != rcsi_pkg::RCSI_SRC_NONE && src != rcsi_pkg::RCSI_SRC_WAKE_WDT
			&& src != rcsi_pkg::RCSI_SRC_WAKE_INT)
		begin
			s_nxt.pc = PC_W'(rcsi_pkg::PC_RESET);
			s_nxt.tos = '0;
			s_nxt.pclat = '0;
			s_nxt.table_pointer = '0;
			s_nxt.tblat = '0;
			s_nxt.sptr = rcsi_pkg::SPTR_RESET;
			s_nxt.intctl = rcsi_pkg::INTCTL_RESET;
			s_nxt.busst = rcsi_pkg::BUSST_RESET;
			s_nxt.pcload = 1'b1;
			s_nxt.crst = 1'b1;
			s_nxt.ev[rcsi_pkg::EV_RESET] = 1'b1;
			if (src == rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG || src == rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG)
				s_nxt.ev[rcsi_pkg::EV_STACK] = 1'b1;
		end
		if (src == rcsi_pkg::RCSI_SRC_WAKE_WDT)
		begin
			s_nxt.pc = PC_W'(s_r.pc + rcsi_pkg::PC_STEP);
			s_nxt.pcload = 1'b1;
			s_nxt.intctl[2] = 1'b1;
			s_nxt.ev[rcsi_pkg::EV_WAKE] = 1'b1;
		end
		if (src == rcsi_pkg::RCSI_SRC_WAKE_INT)
		begin
			s_nxt.pcload = 1'b1;
			// the wake cause must still be visible to the interrupt handler
			if (int_wake_is_pir)
				s_nxt.piflag = s_nxt.piflag | int_wake_src;
			else
				s_nxt.intctl = s_nxt.intctl | int_wake_src;
			if (gie)
			begin
				s_nxt.pc = int_high_prio ? PC_W'(rcsi_pkg::VEC_HIGH)
					: PC_W'(rcsi_pkg::VEC_LOW);
				s_nxt.tos = s_r.pc;
				s_nxt.sptr = 5'(s_r.sptr + 5'h01);
			end
			else
				s_nxt.pc = PC_W'(s_r.pc + rcsi_pkg::PC_STEP);
			s_nxt.ev[rcsi_pkg::EV_WAKE] = 1'b1;
		end
		s_nxt.dat = '0;
		if (rd)
		begin
			case (wb_adr_i)
				rcsi_pkg::ADR_RCAUSE:
					s_nxt.dat[7:0] = s_nxt.rcause & rcsi_pkg::RCAUSE_IMPL;
				rcsi_pkg::ADR_STACK:
					s_nxt.dat[1:0] = s_r.stk;
				rcsi_pkg::ADR_PC:
					s_nxt.dat[PC_W-1:0] = s_r.pc;
				rcsi_pkg::ADR_TOS:
					s_nxt.dat[PC_W-1:0] = s_r.tos;
				rcsi_pkg::ADR_SPTR:
					s_nxt.dat[4:0] = s_r.sptr;
				rcsi_pkg::ADR_PCLAT:
					s_nxt.dat[15:0] = s_r.pclat;
				rcsi_pkg::ADR_TABLE_POINTER:
					s_nxt.dat[21:0] = s_r.table_pointer;
				rcsi_pkg::ADR_TBLAT:
					s_nxt.dat[7:0] = s_r.tblat;
				rcsi_pkg::ADR_INTCTL:
					s_nxt.dat[7:0] = s_r.intctl;
				rcsi_pkg::ADR_PIFLAG:
					s_nxt.dat[7:0] = s_r.piflag;
				rcsi_pkg::ADR_PORTA:
					s_nxt.dat[7:0] = s_r.porta & pa_mask;
				rcsi_pkg::ADR_BUSST:
					s_nxt.dat[7:0] = s_r.busst;
				rcsi_pkg::ADR_IRQ_ST:
					s_nxt.dat[2:0] = s_r.ev;
				rcsi_pkg::ADR_IRQ_MSK:
					s_nxt.dat[2:0] = s_r.msk;
				rcsi_pkg::ADR_OSCMODE:
					s_nxt.dat[2:0] = s_r.oscmode;
				default:
					s_nxt.dat = '0;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			// rstn acts as power-on; bit 1 is reset by the condition, here por
			s_r <= '0;
			s_r.rcause <= rcsi_pkg::RCAUSE_POR;
			s_r.busst <= rcsi_pkg::BUSST_RESET;
			s_r.crst <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign wb_dat_o = s_r.dat;
	assign wb_ack_o = s_r.ack;
	assign pc_o = s_r.pc;
	assign pc_load_o = s_r.pcload;
	assign core_rst_o = s_r.crst;
	assign irq_o = |(s_r.ev & s_r.msk);
endmodule : rcsi_top
`default_nettype wire

/* bench/rcsi_top_sva.sv */
// rcsi_top_sva: port-level assertions for the reset cause block
// assumes one-cycle event pulses and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none
module rcsi_top_sva #(
	parameter int PC_W = 21
) (
	input wire logic            mclk,
	input wire logic            rstn,
	input wire logic            por_evt,
	input wire logic            bor_evt,
	input wire logic            master_clear_pin_evt,
	input wire logic            swrst_evt,
	input wire logic            stack_overflow_flag_evt,
	input wire logic            stack_underflow_flag_evt,
	input wire logic            wdt_evt,
	input wire logic            sleeping,
	input wire logic [7:0]      wb_adr_i,
	input wire logic            wb_we_i,
	input wire logic            wb_cyc_i,
	input wire logic            wb_stb_i,
	input wire logic [31:0]     wb_dat_o,
	input wire logic            wb_ack_o,
	input wire logic [PC_W-1:0] pc_o,
	input wire logic            pc_load_o,
	input wire logic            core_rst_o
);
	logic rsrc;
	logic rd_q;
	// a watchdog event while asleep is a wake, not a reset
	assign rsrc = por_evt | bor_evt | master_clear_pin_evt | swrst_evt | stack_overflow_flag_evt | stack_underflow_flag_evt
		| (wdt_evt & ~sleeping);
	assign rd_q = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	reset_pc_a: assert property (rsrc |=> pc_o == '0 && pc_load_o && core_rst_o)
		else $error("reset source did not restart at zero");
	wake_pc_a: assert property (wdt_evt && sleeping && !por_evt && !bor_evt && !master_clear_pin_evt
		|=> pc_o == $past(pc_o) + PC_W'(2) && pc_load_o && !core_rst_o)
		else $error("watchdog wake did not step pc by two");
	rst_cause_a: assert property ($rose(core_rst_o) |-> $past(rsrc))
		else $error("core reset without a reset source");
	pc_hold_a: assert property (!pc_load_o |-> $stable(pc_o))
		else $error("pc moved without a load");
	unmapped_rd_a: assert property (rd_q && wb_adr_i > 8'h3b |=> wb_dat_o == '0)
		else $error("unmapped read not zero");
	cause_bits_a: assert property (rd_q && wb_adr_i == rcsi_pkg::ADR_RCAUSE
		|=> wb_dat_o[31:8] == '0 && wb_dat_o[6:5] == 2'h0)
		else $error("unimplemented cause bits not zero");
endmodule : rcsi_top_sva
bind rcsi_top rcsi_top_sva #(.PC_W(PC_W)) u_sva (.mclk(mclk), .rstn(rstn), .por_evt(por_evt),
	.bor_evt(bor_evt), .master_clear_pin_evt(master_clear_pin_evt), .swrst_evt(swrst_evt), .stack_overflow_flag_evt(stack_overflow_flag_evt),
	.stack_underflow_flag_evt(stack_underflow_flag_evt), .wdt_evt(wdt_evt), .sleeping(sleeping), .wb_adr_i(wb_adr_i),
	.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pc_o(pc_o), .pc_load_o(pc_load_o), .core_rst_o(core_rst_o));
`default_nettype wire

/* bench/rcsi_src_model.sv */
// rcsi_src_model: reset and wake sources around the core
// assumes fire is raised for one cycle; pulses follow one edge later
`timescale 1ns/1ps
`default_nettype none
module rcsi_src_model (
	input  wire logic                mclk,
	input  wire logic                fire,
	input  wire rcsi_pkg::rcsi_src_e code,
	output logic [6:0]               evt,
	output logic                     sleeping,
	output logic                     wake
);
	initial {evt, sleeping, wake} = 9'h000;
	// sleep is shown only in the event cycle, so stale sleep never leaks into later events
	always @(posedge mclk)
	begin
		{evt, sleeping, wake} <= 9'h000;
		if (fire)
			case (code)
				rcsi_pkg::RCSI_SRC_POR:        evt[0] <= 1'b1;
				rcsi_pkg::RCSI_SRC_BOR:        evt[1] <= 1'b1;
				rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN:       evt[2] <= 1'b1;
				rcsi_pkg::RCSI_SRC_SWRST:      evt[3] <= 1'b1;
				rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG:     evt[4] <= 1'b1;
				rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG:     evt[5] <= 1'b1;
				rcsi_pkg::RCSI_SRC_WDT:        evt[6] <= 1'b1;
				rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN_SLEEP: {evt[2], sleeping} <= 2'h3;
				rcsi_pkg::RCSI_SRC_WAKE_WDT:   {evt[6], sleeping} <= 2'h3;
				rcsi_pkg::RCSI_SRC_WAKE_INT:   {wake, sleeping} <= 2'h3;
				default:                       wake <= 1'b0;
			endcase
	end
endmodule : rcsi_src_model
`default_nettype wire

/* bench/tb_rcsi_top.sv */
// tb_rcsi_top: self-checking bench for the reset cause block
// assumes the package, source model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_rcsi_top;
	logic                mclk = 1'b0;
	logic                rstn = 1'b0;
	logic                fire = 1'b0;
	rcsi_pkg::rcsi_src_e code = rcsi_pkg::RCSI_SRC_NONE;
	logic [6:0]          evt;
	logic                slp;
	logic                wake;
	logic                hip = 1'b0;
	logic [7:0]          src = 8'h00;
	logic [7:0]          adr = 8'h00;
	logic [31:0]         dat = 32'h0;
	logic                we = 1'b0;
	logic                cyc = 1'b0;
	logic [31:0]         rdat;
	logic                ack;
	logic [20:0]         pc;
	logic                irq;
	logic [31:0]         expq[$];
	logic [7:0]          rc;
	logic [20:0]         epc;
	logic [20:0]         tos;
	logic [31:0]         rnd = 32'h4faf;
	logic [31:0]         exp_rd;
	logic                peripheral_int_flags = 1'b1;
	int                  fails = 0;
	int                  n_tests = 0;
	rcsi_pkg::rcsi_src_e seq[10] = '{rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN, rcsi_pkg::RCSI_SRC_SWRST,
		rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG, rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG, rcsi_pkg::RCSI_SRC_WDT,
		rcsi_pkg::RCSI_SRC_BOR, rcsi_pkg::RCSI_SRC_POR, rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN_SLEEP,
		rcsi_pkg::RCSI_SRC_WAKE_WDT, rcsi_pkg::RCSI_SRC_WAKE_INT};
	always #5 mclk = ~mclk;
	rcsi_src_model src_m (.mclk(mclk), .fire(fire), .code(code), .evt(evt), .sleeping(slp),
		.wake(wake));
	rcsi_top dut (.mclk(mclk), .rstn(rstn), .por_evt(evt[0]), .bor_evt(evt[1]),
		.master_clear_pin_evt(evt[2]), .swrst_evt(evt[3]), .stack_overflow_flag_evt(evt[4]), .stack_underflow_flag_evt(evt[5]),
		.wdt_evt(evt[6]), .sleeping(slp), .int_wake_evt(wake), .int_high_prio(hip),
		.int_wake_src(src), .int_wake_is_pir(peripheral_int_flags), .wb_adr_i(adr), .wb_dat_i(dat),
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pc_o(pc), .pc_load_o(), .core_rst_o(), .irq_o(irq));
	// read results are matched in issue order against the noted expectations
	always @(posedge mclk)
		if (ack === 1'b1 && we === 1'b0)
		begin
			// popped once: the compare macro reads its arguments twice
			exp_rd = expq.pop_front();
			`CHK(rdat, exp_rd)
		end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	function automatic logic [7:0] nrc(input logic [7:0] r, input rcsi_pkg::rcsi_src_e c);
		case (c)
			rcsi_pkg::RCSI_SRC_POR:        r[4:0] = 5'h1c;
			rcsi_pkg::RCSI_SRC_BOR:        {r[4:2], r[0]} = 4'he;
			rcsi_pkg::RCSI_SRC_SWRST:      r[4] = 1'b0;
			rcsi_pkg::RCSI_SRC_STACK_OVERFLOW_FLAG,
			rcsi_pkg::RCSI_SRC_STACK_UNDERFLOW_FLAG:     r[1:0] = 2'h3;
			rcsi_pkg::RCSI_SRC_WDT:        r[3:2] = 2'h1;
			rcsi_pkg::RCSI_SRC_WAKE_WDT:   r[3:2] = 2'h0;
			rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN_SLEEP,
			rcsi_pkg::RCSI_SRC_WAKE_INT:   r[3:2] = 2'h2;
			default:                       r = r;
		endcase
		return r;
	endfunction : nrc
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report
	// entered just after an edge; leaves one idle cycle so cyc never rises in the ack edge
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		adr <= a;
		we <= w;
		dat <= d;
		cyc <= 1'b1;
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge mclk);
		cyc <= 1'b0;
		if (ack !== 1'b1)
		begin
			fails++;
			final_report();
		end
		else
			@(posedge mclk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		wb(a, 1'b0, 32'h0);
	endtask : rd
	task automatic ev(input rcsi_pkg::rcsi_src_e c);
		code <= c;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (3) @(posedge mclk);
		rc = nrc(rc, c);
		tos = epc;
		epc = (c == rcsi_pkg::RCSI_SRC_WAKE_WDT || c == rcsi_pkg::RCSI_SRC_WAKE_INT) ?
			epc + 21'h2 : 21'h0;
	endtask : ev
	task automatic irqc(input logic e);
		repeat (2) @(posedge mclk);
		`CHK(irq, e)
	endtask : irqc
	initial
	begin
		rc = 8'h1c;
		epc = 21'h0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rd(rcsi_pkg::ADR_RCAUSE, 32'h1c);
		rd(rcsi_pkg::ADR_BUSST, 32'h80);
		rd(8'h3c, 32'h0);
		$display("test reset values done");
		wb(rcsi_pkg::ADR_IRQ_MSK, 1'b1, 32'h2);
		rnd = lfsr(rnd);
		src <= rnd[7:0] | 8'h01;
		foreach (seq[k])
		begin
			ev(seq[k]);
			rd(rcsi_pkg::ADR_RCAUSE, {24'h0, rc});
			rd(rcsi_pkg::ADR_PC, {11'h0, epc});
			`CHK(pc, epc)
		end
		rd(rcsi_pkg::ADR_STACK, 32'h3);
		rd(rcsi_pkg::ADR_PIFLAG, {24'h0, src});
		$display("test cause flags done");
		irqc(1'b1);
		wb(rcsi_pkg::ADR_IRQ_MSK, 1'b1, 32'h0);
		irqc(1'b0);
		wb(rcsi_pkg::ADR_IRQ_MSK, 1'b1, 32'h2);
		irqc(1'b1);
		wb(rcsi_pkg::ADR_IRQ_ST, 1'b1, 32'h2);
		irqc(1'b0);
		$display("test interrupt done");
		wb(rcsi_pkg::ADR_INTCTL, 1'b1, 32'h80);
		// wake cause now lands in the interrupt control register
		peripheral_int_flags <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			hip <= (k == 0);
			ev(rcsi_pkg::RCSI_SRC_WAKE_INT);
			epc = k ? rcsi_pkg::VEC_LOW : rcsi_pkg::VEC_HIGH;
			rd(rcsi_pkg::ADR_PC, {11'h0, epc});
			rd(rcsi_pkg::ADR_TOS, {11'h0, tos});
			rd(rcsi_pkg::ADR_SPTR, 32'(k + 1));
		end
		rd(rcsi_pkg::ADR_INTCTL, {24'h0, src | 8'h80});
		ev(rcsi_pkg::RCSI_SRC_MASTER_CLEAR_PIN);
		rd(rcsi_pkg::ADR_TOS, 32'h0);
		rd(rcsi_pkg::ADR_TABLE_POINTER, 32'h0);
		$display("test vectored wake done");
		for (int m = 0; m < 8; m++)
		begin
			wb(rcsi_pkg::ADR_OSCMODE, 1'b1, 32'(m));
			wb(rcsi_pkg::ADR_PORTA, 1'b1, 32'h40);
			rd(rcsi_pkg::ADR_PORTA, (3'(m) == rcsi_pkg::OSC_EXT_CLOCK_IO_MODE || 3'(m) == rcsi_pkg::OSC_RC_OSC_IO_MODE)
				? 32'h40 : 32'h0);
		end
		$display("test port bit done");
		repeat (3) @(posedge mclk);
		// every noted read must have been answered
		`CHK(expq.size(), 0)
		final_report();
	end
endmodule : tb_rcsi_top
`default_nettype wire
